// ===== src/hbs_pkg.sv
// Package for the holding brake sequencer with brake PWM.
// Assumes a single 10 MHz controller clock; no imports are used by clients.
package hbs_pkg;
  // Clock rate and timing.
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // Configuration field positions.
  localparam int unsigned SUBMODE_AUTO_BIT = 2;
  localparam int unsigned DOUT_BRAKE_BIT = 0;
  // Frequency and duty limits.
  localparam logic [15:0] FREQ_MIN_HZ = 16'h0032;
  localparam logic [15:0] FREQ_MAX_HZ = 16'h4e20;
  localparam logic [6:0] DUTY_MIN_PCT = 7'h02;
  localparam logic [6:0] DUTY_MAX_PCT = 7'h64;
  // Reset values of the PWM settings.
  localparam logic [15:0] FREQ_RST_HZ = 16'h07d0;
  localparam logic [6:0] DUTY_RST_PCT = 7'h64;

  // Four sequencing delays in milliseconds.
  typedef struct packed {
    logic [15:0] stop_to_engage_ms;
    logic [15:0] engage_to_off_ms;
    logic [15:0] on_to_release_ms;
    logic [15:0] release_to_enable_ms;
  } hbs_delays_s;

  // Sequencer states, one-hot.
  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_ON_WAIT = 7'h02,
    ST_REL_WAIT = 7'h04,
    ST_ENABLED = 7'h08,
    ST_STOP = 7'h10,
    ST_ENG_WAIT = 7'h20,
    ST_OFF_WAIT = 7'h40
  } hbs_state_e;
endpackage : hbs_pkg

// ===== src/hbs_pwm.sv
// PWM generator for the energised brake.
// Assumes frequency and duty already validated by the caller.
`timescale 1ns/1ns
module hbs_pwm #(
  parameter int unsigned CLK_HZ = 10000000
) (
  // Clock and control.
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Settings.
  input wire logic [15:0] i_freq_hz,
  input wire logic [6:0] i_duty_pct,
  // Waveform.
  output logic o_pwm
);
  logic [23:0] period_q;
  logic [23:0] high_q;
  logic [23:0] cnt_q;

  // Cycles per PWM period for a frequency in hertz.
  function automatic logic [31:0] period_of(input logic [15:0] f);
    period_of = CLK_HZ / 32'(f);
  endfunction : period_of

  //////////////////////////////////////////////////////////////////////////////
  // Period and high time in cycles; recomputed each cycle, cheap at this rate.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      period_q <= 24'h000001;
      high_q <= 24'h000001;
    end else if (i_ce) begin
      period_q <= 24'(period_of(i_freq_hz));
      high_q <= 24'(period_of(i_freq_hz) * 32'(i_duty_pct) / 32'(hbs_pkg::DUTY_MAX_PCT));
    end
  end

  // Free-running period counter and compare.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cnt_q <= 24'h000000;
      o_pwm <= 1'b0;
    end else if (i_ce) begin
      cnt_q <= (cnt_q + 24'h000001 >= period_q) ? 24'h000000 : cnt_q + 24'h000001;
      o_pwm <= (i_duty_pct >= hbs_pkg::DUTY_MAX_PCT) || (cnt_q < high_q);
    end
  end
endmodule : hbs_pwm

// ===== src/hbs_top.sv
// Holding brake sequencer: power-stage sequencing plus brake PWM output.
// Assumes synchronous inputs on i_mclk and a drive that reports standstill.
// The brake output is high while the coil is energised, that is, while the brake is open.
// How it works
// - Automatic mode releases brake only around Operation enabled.
// - Automatic mode keeps brake engaged in every other state.
// - Submode bit 2 selects automatic (1) or manual (0) brake handling.
// - Manual mode drives brake from digital outputs bit 0.
// - Enable: current on, delay 3, release, delay 4, operation enabled.
// - Disable: stop motor, delay 1, engage, delay 2, current off.
// - Brake PWM frequency from setting 5, limited 50 to 20000 Hz.
// - Duty from setting 6, whole percent, 2 to 100.
// - Duty 100 holds the output steadily on.
// - Automatic control uses the sequencer release, not output bit 0; PWM also offered for routing.
`timescale 1ns/1ns
module hbs_top (
  // Clock, reset and enable.
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Configuration.
  input wire logic [15:0] i_drive_submode,
  input wire logic [15:0] i_digital_outputs,
  input wire hbs_pkg::hbs_delays_s i_delays,
  input wire logic i_freq_wr,
  input wire logic [15:0] i_freq_hz,
  input wire logic i_duty_wr,
  input wire logic [6:0] i_duty_pct,
  // Power state machine handshake.
  input wire logic i_enable_req,
  input wire logic i_standstill,
  // Outputs.
  output logic o_brake_output_connector,
  output logic o_brake_pwm_route,
  output logic o_motor_current_on,
  output logic o_stop_request,
  output logic o_operation_enabled,
  output logic [15:0] o_freq_hz,
  output logic [6:0] o_duty_pct
);
  hbs_pkg::hbs_state_e state_q;
  hbs_pkg::hbs_state_e state_d;
  logic [23:0] tick_cnt_q;
  logic tick_q;
  logic [15:0] dly_q;
  logic release_q;
  logic pwm;
  logic auto_mode;
  logic dly_done;
  // High for one enabled cycle on each step entry.
  logic step_entry;

  // Range check shared by both setting writes.
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // Delay loaded on entry to a step; untimed steps load zero so they never wait.
  // The four delays are in milliseconds and each waits whole ticks.
  function automatic logic [15:0] step_delay(input hbs_pkg::hbs_state_e s, input hbs_pkg::hbs_delays_s d);
    case (s)
      hbs_pkg::ST_ON_WAIT: step_delay = d.on_to_release_ms;
      hbs_pkg::ST_REL_WAIT: step_delay = d.release_to_enable_ms;
      hbs_pkg::ST_ENG_WAIT: step_delay = d.stop_to_engage_ms;
      hbs_pkg::ST_OFF_WAIT: step_delay = d.engage_to_off_ms;
      default: step_delay = 16'h0000;
    endcase
  endfunction : step_delay

  // Steps of the disable path before the brake closes: the motor is being stopped,
  // and a brake that is already open stays open until the stop delay has run.
  function automatic logic in_stop_path(input hbs_pkg::hbs_state_e s);
    case (s)
      hbs_pkg::ST_STOP: in_stop_path = 1'b1;
      hbs_pkg::ST_ENG_WAIT: in_stop_path = 1'b1;
      default: in_stop_path = 1'b0;
    endcase
  endfunction : in_stop_path

  assign auto_mode = i_drive_submode[hbs_pkg::SUBMODE_AUTO_BIT];
  assign dly_done = (dly_q == 16'h0000);
  // A step is entered on the enabled edge at which the next state differs;
  // both the tick and the delay counter restart there.
  assign step_entry = i_ce && (state_d != state_q);

  //////////////////////////////////////////////////////////////////////////////
  // Settings: a rejected write leaves the PWM running on its last good values.
  // Limits are checked before the store, so the generator never sees an illegal value.
  // A write made while i_ce is low is lost, as all state is frozen then.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_freq_hz <= hbs_pkg::FREQ_RST_HZ;
      o_duty_pct <= hbs_pkg::DUTY_RST_PCT;
    end else if (i_ce) begin
      if (i_freq_wr && in_range(i_freq_hz, hbs_pkg::FREQ_MIN_HZ, hbs_pkg::FREQ_MAX_HZ)) begin
        o_freq_hz <= i_freq_hz;
      end
      if (i_duty_wr && in_range({9'h000, i_duty_pct}, {9'h000, hbs_pkg::DUTY_MIN_PCT},
                                {9'h000, hbs_pkg::DUTY_MAX_PCT})) begin
        o_duty_pct <= i_duty_pct;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond tick; resets when a delay is loaded so a step waits whole ms.
  // The cost is up to two extra cycles per step, far below one millisecond, in
  // exchange for never cutting the first millisecond of a step short.
  always_ff @(posedge i_mclk) begin
    if (i_srst || step_entry) begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b0;
    end else if (i_ce) begin
      tick_q <= (tick_cnt_q == 24'(hbs_pkg::TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == 24'(hbs_pkg::TICK_CYCLES - 1)) ? 24'h000000 : tick_cnt_q + 24'h000001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state; leaving any step of the enable path takes the disable path.
  // The stop step waits for standstill without a limit: the drive is trusted
  // to report it, as nothing here can force the motor to rest.
  // Any value outside the one-hot codes falls back to the off state.
  always_comb begin
    state_d = state_q;
    case (state_q)
      hbs_pkg::ST_OFF: if (i_enable_req) state_d = hbs_pkg::ST_ON_WAIT;
      hbs_pkg::ST_ON_WAIT: begin
        if (!i_enable_req) state_d = hbs_pkg::ST_STOP;
        else if (dly_done) state_d = hbs_pkg::ST_REL_WAIT;
      end
      hbs_pkg::ST_REL_WAIT: begin
        if (!i_enable_req) state_d = hbs_pkg::ST_STOP;
        else if (dly_done) state_d = hbs_pkg::ST_ENABLED;
      end
      hbs_pkg::ST_ENABLED: if (!i_enable_req) state_d = hbs_pkg::ST_STOP;
      hbs_pkg::ST_STOP: if (i_standstill) state_d = hbs_pkg::ST_ENG_WAIT;
      hbs_pkg::ST_ENG_WAIT: if (dly_done) state_d = hbs_pkg::ST_OFF_WAIT;
      hbs_pkg::ST_OFF_WAIT: if (dly_done) state_d = hbs_pkg::ST_OFF;
      default: state_d = hbs_pkg::ST_OFF;
    endcase
  end

  // State register.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_q <= hbs_pkg::ST_OFF;
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Delay down-counter, loaded on entry to each timed step.
  // The delay values are read only at step entry, so a change made mid-step
  // applies to the next step, not to the one that is running.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      dly_q <= 16'h0000;
    end else if (i_ce) begin
      if (step_entry) begin
        dly_q <= step_delay(state_d, i_delays);
      end else if (tick_q && !dly_done) begin
        dly_q <= dly_q - 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer outputs, registered.
  // Each is decoded from the next state so that it changes on the same edge as the state.
  // Motor current stays on until the off delay has run out.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_motor_current_on <= 1'b0;
      o_stop_request <= 1'b0;
      o_operation_enabled <= 1'b0;
      release_q <= 1'b0;
    end else if (i_ce) begin
      o_motor_current_on <= (state_d != hbs_pkg::ST_OFF);
      o_stop_request <= in_stop_path(state_d);
      o_operation_enabled <= (state_d == hbs_pkg::ST_ENABLED);
      // Release starts only in the release step; the stop path merely keeps it.
      release_q <= (state_d == hbs_pkg::ST_REL_WAIT) || (state_d == hbs_pkg::ST_ENABLED)
                   || (release_q && in_stop_path(state_d));
    end
  end

  // PWM generator, free running; gated onto the brake only when energised.
  // It runs on the stored settings only, so a refused write can never reach it.
  hbs_pwm #(
    .CLK_HZ(hbs_pkg::CLK_HZ)
  ) u_pwm (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_freq_hz(o_freq_hz),
    .i_duty_pct(o_duty_pct),
    .o_pwm(pwm)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Brake driver: energised means released, and an energised brake carries the PWM.
  // The routed copy is the raw waveform; any gating by an output bit is left to the
  // routing stage, so the copy keeps running even while the brake is closed.
  // The one-cycle lag behind the generator is the price of a flip-flop output.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_brake_output_connector <= 1'b0;
      o_brake_pwm_route <= 1'b0;
    end else if (i_ce) begin
      if (auto_mode) begin
        o_brake_output_connector <= release_q && pwm;
      end else begin
        o_brake_output_connector <= i_digital_outputs[hbs_pkg::DOUT_BRAKE_BIT] && pwm;
      end
      o_brake_pwm_route <= pwm;
    end
  end
endmodule : hbs_top

// ===== verif/hbs_brake_model.sv
// Behavioural holding brake on the brake output connector.
// Assumes the coil level is sampled on the controller clock.
`timescale 1ns/1ns
module hbs_brake_model (
  // Clock and count control.
  input wire logic i_mclk,
  input wire logic i_clr,
  // Coil drive and count.
  input wire logic i_coil,
  output logic [15:0] o_on_cycles
);
  // Energised cycles are counted so that a whole PWM period gives the high time.
  always_ff @(posedge i_mclk) begin
    if (i_clr) begin
      o_on_cycles <= 16'h0000;
    end else begin
      o_on_cycles <= o_on_cycles + {15'h0000, i_coil};
    end
  end
endmodule : hbs_brake_model

// ===== verif/hbs_chk.sv
// Port assertions for the brake sequencer.
// Assumes the package is compiled first; bound below.
`timescale 1ns/1ns
module hbs_chk (
  // Watched ports.
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [15:0] i_drive_submode,
  input wire logic [15:0] i_digital_outputs,
  input wire logic i_freq_wr,
  input wire logic [15:0] i_freq_hz,
  input wire logic i_duty_wr,
  input wire logic [6:0] i_duty_pct,
  input wire logic o_brake_output_connector,
  input wire logic o_brake_pwm_route,
  input wire logic o_motor_current_on,
  input wire logic o_stop_request,
  input wire logic o_operation_enabled,
  input wire logic [15:0] o_freq_hz,
  input wire logic [6:0] o_duty_pct
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////
  // Three cycles of margin cover the one-cycle lag of the connector.
  a_op_current: assert property (o_operation_enabled |-> o_motor_current_on)
    else $error("operation enabled without motor current");
  a_op_released: assert property ((i_ce && o_operation_enabled && i_drive_submode[2] && o_duty_pct == 7'h64) [*3]
    |-> o_brake_output_connector) else $error("brake closed in operation enabled");
  a_stop_current: assert property (o_stop_request |-> o_motor_current_on)
    else $error("stop request without motor current");
  a_freq_range: assert property (o_freq_hz >= 16'h0032 && o_freq_hz <= 16'h4e20)
    else $error("frequency out of range");
  a_duty_range: assert property (o_duty_pct >= 7'h02 && o_duty_pct <= 7'h64)
    else $error("duty out of range");
  a_freq_taken: assert property ((i_ce && i_freq_wr && i_freq_hz >= 16'h0032 && i_freq_hz <= 16'h4e20)
    |=> o_freq_hz == $past(i_freq_hz)) else $error("valid frequency write lost");
  a_duty_refused: assert property ((i_ce && i_duty_wr && (i_duty_pct < 7'h02 || i_duty_pct > 7'h64))
    |=> $stable(o_duty_pct)) else $error("bad duty write taken");
  a_full_duty: assert property ((i_ce && o_duty_pct == 7'h64) [*3] |-> o_brake_pwm_route)
    else $error("full duty output not steady");
  a_manual_off: assert property ((i_ce && !i_drive_submode[2] && !i_digital_outputs[0]) [*3]
    |-> !o_brake_output_connector) else $error("manual brake released");
  a_auto_closed: assert property ((i_ce && i_drive_submode[2] && !o_motor_current_on) [*3]
    |-> !o_brake_output_connector) else $error("auto brake released with current off");
endmodule : hbs_chk
bind hbs_top hbs_chk hbs_chk_i (.i_mclk, .i_srst, .i_ce, .i_drive_submode, .i_digital_outputs, .i_freq_wr,
  .i_freq_hz, .i_duty_wr, .i_duty_pct, .o_brake_output_connector, .o_brake_pwm_route, .o_motor_current_on,
  .o_stop_request, .o_operation_enabled, .o_freq_hz, .o_duty_pct);

// ===== verif/tb_top.sv
// Self-checking bench for the brake sequencer.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/1ns
`define chk(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_top;
  logic clk = 1'b0, rst = 1'b1, fwr = 1'b0, dwr = 1'b0, en = 1'b0, stand = 1'b0, clr = 1'b0, ce = 1'b1;
  logic [15:0] sub = 16'h0000, dout = 16'h0000, fhz = 16'h0000, on_cnt, ofq;
  logic [6:0] dpc = 7'h00, odt;
  logic brk, rte, cur, stp, ope;
  hbs_pkg::hbs_delays_s dly = 64'h0;
  int errors = 0, checked = 0, cycles = 0;
  hbs_top hbs_top_i (.i_mclk(clk), .i_srst(rst), .i_ce(ce), .i_drive_submode(sub), .i_digital_outputs(dout),
    .i_delays(dly), .i_freq_wr(fwr), .i_freq_hz(fhz), .i_duty_wr(dwr), .i_duty_pct(dpc), .i_enable_req(en),
    .i_standstill(stand), .o_brake_output_connector(brk), .o_brake_pwm_route(rte), .o_motor_current_on(cur),
    .o_stop_request(stp), .o_operation_enabled(ope), .o_freq_hz(ofq), .o_duty_pct(odt));
  hbs_brake_model hbs_brake_model_i (.i_mclk(clk), .i_clr(clr), .i_coil(brk), .o_on_cycles(on_cnt));
  ////////////////////////////////////////
  // Clock and a hang guard; two one-ms delays bound the run.
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      stop_test();
    end
  end
  task stop_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Waited-on outputs picked by number: 0 current, 1 operation enabled, 2 stop request.
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = cur;
      1: pick = ope;
      default: pick = stp;
    endcase
  endfunction : pick
  task automatic wt(input int sel, input logic v, input int lim, output int n);
    n = 0;
    while (pick(sel) !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wt
  // Single-cycle setting writes; the answer stands from one cycle later, and the idle
  // cycle before the check keeps the strobe low for an edge between two writes.
  task wf(input logic [15:0] v, e);
    fwr = 1'b1;
    fhz = v;
    cyc(1);
    fwr = 1'b0;
    cyc(1);
    `chk("freq", e, ofq)
  endtask : wf
  task wd(input logic [6:0] v, e);
    dwr = 1'b1;
    dpc = v;
    cyc(1);
    dwr = 1'b0;
    cyc(1);
    `chk("duty", e, odt)
  endtask : wd
  // Limits and one step beyond each of them, except the duty minimum itself.
  task t_cfg;
    `chk("freq_rst", 16'h07d0, ofq)
    `chk("duty_rst", 7'h64, odt)
    wf(16'h0032, 16'h0032);
    wf(16'h0031, 16'h0032);
    wf(16'h4e21, 16'h0032);
    wf(16'h4e20, 16'h4e20);
    ce = 1'b0;
    wf(16'h0032, 16'h4e20);
    ce = 1'b1;
    wd(7'h64, 7'h64);
    wd(7'h01, 7'h64);
    wd(7'h65, 7'h64);
  endtask : t_cfg
  // One 500-cycle period at 20 kHz gives the high time exactly.
  task t_pwm(input logic [6:0] d, input logic [15:0] e);
    wd(d, d);
    cyc(1000);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(500);
    `chk("on_cycles", e, on_cnt)
  endtask : t_pwm
  task t_man;
    sub = 16'h0000;
    dout = 16'h0001;
    t_pwm(7'h02, 16'h000a);
    t_pwm(7'h32, 16'h00fa);
    t_pwm(7'h64, 16'h01f4);
    dout = 16'h0000;
    cyc(3);
    `chk("manual_off", 1'b0, brk)
  endtask : t_man
  // Enable then disable; the output bit stays low so release comes from the sequencer.
  task t_auto(input logic [15:0] d3, input int lo, hi);
    int n;
    sub = 16'h0004;
    dly.on_to_release_ms = d3;
    en = 1'b1;
    wt(0, 1'b1, 3, n);
    `chk("current_on", 1'b1, cur)
    `chk("closed_at_current_on", 1'b0, brk)
    wt(1, 1'b1, 30000, n);
    `chk("release_wait", 1'b1, n >= lo && n <= hi)
    cyc(2);
    `chk("released", 1'b1, brk)
    en = 1'b0;
    wt(2, 1'b1, 3, n);
    `chk("stop_req", 1'b1, stp)
    cyc(20);
    `chk("current_held", 1'b1, cur)
    `chk("op_dropped", 1'b0, ope)
    `chk("open_while_stopping", 1'b1, brk)
    stand = 1'b1;
    wt(0, 1'b0, 30000, n);
    `chk("current_off", 1'b0, cur)
    `chk("engaged", 1'b0, brk)
    stand = 1'b0;
  endtask : t_auto
  // Enable dropped before release: the brake never opens, and current waits out delay 2.
  task t_abort;
    int n;
    dly.engage_to_off_ms = 16'h0001;
    en = 1'b1;
    cyc(20);
    en = 1'b0;
    wt(2, 1'b1, 3, n);
    `chk("abort_stop", 1'b1, stp)
    cyc(20);
    `chk("abort_closed", 1'b0, brk)
    stand = 1'b1;
    cyc(20);
    `chk("current_kept", 1'b1, cur)
    wt(0, 1'b0, 30000, n);
    `chk("abort_off", 1'b0, cur)
    `chk("off_wait", 1'b1, n >= 9970 && n <= 10010)
    stand = 1'b0;
  endtask : t_abort
  initial begin
    cyc(6);
    rst = 1'b0;
    cyc(1);
    t_cfg();
    t_man();
    t_auto(16'h0000, 0, 5);
    t_auto(16'h0001, 10000, 20010);
    t_abort();
    stop_test();
  end
endmodule : tb_top
